// [dqc_pkg.sv]
// constants shared by the reference calibration controller and its timer
// assumes a single 10 MHz system clock that also paces the memory command bus
`default_nettype none
package dqc_pkg;
  // clock rate
  localparam int CLK_PERIOD_NS = 100;
  // delays in their own unit, plain defaults
  localparam int ENTRY_DELAY_NS = 150;
  localparam int EXIT_DELAY_NS = 150;
  localparam int SETTLE_SHORT_NS = 150;
  localparam int SETTLE_LONG_NS = 250;
  localparam int PRECHARGE_NS = 15;

  // least time to whole cycles, never below one
  function automatic logic [7:0] dqc_ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) begin
      c = 1;
    end
    return 8'(c);
  endfunction

  localparam logic [7:0] ENTRY_CYC = dqc_ns_to_cyc(ENTRY_DELAY_NS);
  localparam logic [7:0] EXIT_CYC = dqc_ns_to_cyc(EXIT_DELAY_NS);
  localparam logic [7:0] SETTLE_SHORT_CYC = dqc_ns_to_cyc(SETTLE_SHORT_NS);
  localparam logic [7:0] SETTLE_LONG_CYC = dqc_ns_to_cyc(SETTLE_LONG_NS);
  localparam logic [7:0] PRECHARGE_CYC = dqc_ns_to_cyc(PRECHARGE_NS);

  // reference mode register address on bank group / bank pins
  localparam logic [1:0] REF_MR_BG = 2'h1;
  localparam logic [1:0] REF_MR_BA = 2'h2;
  // reference mode register field positions and the auto-precharge address bit
  localparam int REF_EN_BIT = 7;
  localparam int REF_RANGE_BIT = 6;
  localparam int ADDR_AUTO_BIT = 10;
  // range encodings
  localparam logic RANGE_UPPER = 1'b0;
  localparam logic RANGE_LOWER = 1'b1;
  // ladder: top legal step, base and step in hundredths of a percent
  localparam logic [5:0] LEVEL_TOP = 6'h32;
  localparam logic [13:0] LADDER_BASE_UPPER = 14'h1770;
  localparam logic [13:0] LADDER_BASE_LOWER = 14'h1194;
  localparam logic [13:0] LADDER_STEP = 14'h0041;
  // steps above which the long settling time applies
  localparam logic [5:0] LONG_STEP_THRESH = 6'h04;
  // temperature drift that asks for a new calibration
  localparam logic [7:0] TEMP_DRIFT = 8'h0a;
  // reset values
  localparam logic [5:0] LEVEL_RESET = 6'h00;
  localparam logic [7:0] TEMP_RESET = 8'h00;

  // user orders
  localparam logic [1:0] OP_ENTER = 2'h0;
  localparam logic [1:0] OP_SET = 2'h1;
  localparam logic [1:0] OP_TRAFFIC = 2'h2;
  localparam logic [1:0] OP_EXIT = 2'h3;
  // traffic kinds
  localparam logic [1:0] TR_ACT = 2'h0;
  localparam logic [1:0] TR_WR = 2'h1;
  localparam logic [1:0] TR_RD = 2'h2;
  localparam logic [1:0] TR_PRE = 2'h3;
  // ras/cas/we codes on a[16:14] with act_n high
  localparam logic [2:0] RCW_MRS = 3'h0;
  localparam logic [2:0] RCW_WR = 3'h4;
  localparam logic [2:0] RCW_RD = 3'h5;
  localparam logic [2:0] RCW_PRE = 3'h2;

  // kind of command currently on the pins
  typedef enum logic [2:0] {
    K_DES, K_ENTER, K_SET, K_EXIT, K_TR, K_PRE
  } dqc_kind_type;
endpackage
`default_nettype wire

// [dqc_wait_timer.sv]
// down counter that spaces commands on the memory command bus
// assumes load is a one-cycle request from logic on the same clock
`default_nettype none
module dqc_wait_timer
  import dqc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // load request
  input wire logic load,
  input wire logic [7:0] load_val,
  // status
  output logic done
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;

  // load wins, otherwise count down to zero
  assign cnt_d = load ? load_val : ((cnt_q == 8'h00) ? 8'h00 : cnt_q - 8'h01);
  assign done = (cnt_q == 8'h00);

  // counter register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

// [dqc_calibration_ctrl.sv]
// controller that runs data-input reference calibration on a memory device
// assumes user orders and status inputs come from logic on clk_sys
//
// What this block does
// - controller waits the entry delay before any calibration command
// - in calibration only activate, read, write, precharge, deselect, mode writes
// - level writes keep enable set and range unchanged, code in level field
// - controller waits short or long settle time after each level write
// - with per-device addressing only mode writes are issued
// - exit command only with all banks precharged
// - only deselects until the exit delay has elapsed
// - exit is a final level write, then a write with enable zero
// - range chosen only on entry, never altered later
// - no new level code on the entry command
// - settle time of the last level met before disabling calibration
// - ask for recalibration when temperature drifts from the calibration temperature
// - reference has no value at power-up until calibration sets one
`default_nettype none
module dqc_calibration_ctrl
  import dqc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // user orders
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic cmd_range,
  input wire logic [5:0] cmd_level,
  input wire logic [1:0] cmd_traffic,
  input wire logic cmd_auto,
  input wire logic [3:0] cmd_bank,
  input wire logic [17:0] cmd_addr,
  output logic cmd_ready,
  output logic cmd_err,
  // system status
  input wire logic pda_active,
  input wire logic [7:0] temp_code,
  output logic cal_active,
  output logic ref_valid,
  output logic ref_range,
  output logic [5:0] ref_level,
  output logic [13:0] ref_level_bp,
  output logic recal_needed,
  // memory command pins
  output logic ddr_cs_n,
  output logic ddr_act_n,
  output logic [1:0] ddr_bg,
  output logic [1:0] ddr_ba,
  output logic [17:0] ddr_a
);
  typedef enum logic [2:0] {
    S_OFF, S_CAL, S_EXIT_PRE, S_EXIT_MRS, S_EXIT_WAIT
  } dqc_state_type;

  dqc_state_type state_q, state_d;
  logic range_q, range_d;
  logic [5:0] level_q, level_d;
  logic [15:0] open_q, open_d;
  logic ref_valid_q, ref_range_q;
  logic [5:0] ref_level_q;
  logic [13:0] bp_q, bp_d;
  logic [7:0] cal_temp_q;
  logic recal_q, recal_d;
  logic err_q;
  logic cs_n_q, act_n_q;
  logic [1:0] bg_q, ba_q;
  logic [17:0] a_q, a_d;
  dqc_kind_type kind_q, kind_d;

  // timer handshake
  logic wait_done, load_en;
  logic [7:0] load_val;

  // order decode
  logic take, level_ok, bank_open, tr_ok;
  logic ok_enter, ok_set, ok_exit, ok_tr, refuse;
  logic [5:0] delta;
  logic step_long, exit_prea, exit_mrs, commit;
  logic [7:0] settle_cyc, tdiff;
  logic [17:0] a_mrs, a_tr, a_prea;
  logic [2:0] rcw_tr;

  dqc_wait_timer u_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .load(load_en),
    .load_val(load_val),
    .done(wait_done)
  );

  // handshake: orders only between timed gaps, in off or calibration state
  assign cmd_ready = wait_done && (state_q == S_OFF || state_q == S_CAL);
  assign take = cmd_valid && cmd_ready;
  assign cal_active = (state_q != S_OFF);

  // order checks
  assign level_ok = (cmd_level <= LEVEL_TOP);
  assign bank_open = open_q[cmd_bank];
  assign tr_ok = (cmd_traffic == TR_ACT) ? !bank_open :
                 (cmd_traffic == TR_PRE) ? 1'b1 : bank_open;
  assign ok_enter = take && state_q == S_OFF && cmd_op == OP_ENTER;
  assign ok_set = take && state_q == S_CAL && cmd_op == OP_SET && level_ok;
  // no exit while per-device addressing would force a precharge of open banks
  assign ok_exit = take && state_q == S_CAL && cmd_op == OP_EXIT && level_ok
                   && !(pda_active && open_q != 16'h0000);
  assign ok_tr = take && state_q == S_CAL && cmd_op == OP_TRAFFIC
                 && !pda_active && tr_ok;
  assign refuse = take && !(ok_enter || ok_set || ok_exit || ok_tr);

  // exit sequence steps, precharge only when a bank is still open
  assign exit_prea = state_q == S_EXIT_PRE && wait_done && (open_q != 16'h0000);
  assign exit_mrs = state_q == S_EXIT_MRS && wait_done;
  assign commit = state_q == S_EXIT_WAIT && wait_done;

  // step size picks the settling time
  assign delta = (cmd_level >= level_q) ? cmd_level - level_q : level_q - cmd_level;
  assign step_long = (delta > LONG_STEP_THRESH);
  assign settle_cyc = step_long ? SETTLE_LONG_CYC : SETTLE_SHORT_CYC;

  // timer loads
  assign load_en = ok_enter || ok_set || ok_exit || exit_prea || exit_mrs;
  assign load_val = ok_enter ? ENTRY_CYC :
                    exit_prea ? PRECHARGE_CYC :
                    exit_mrs ? EXIT_CYC : settle_cyc;

  // mode write word: entry carries level zero, later writes keep the range
  assign a_mrs = {1'b0, RCW_MRS, 6'h00, !exit_mrs,
                  ok_enter ? cmd_range : range_q,
                  (ok_enter || exit_mrs) ? 6'h00 : cmd_level};

  // traffic word
  assign rcw_tr = (cmd_traffic == TR_WR) ? RCW_WR :
                  (cmd_traffic == TR_RD) ? RCW_RD : RCW_PRE;
  assign a_tr = (cmd_traffic == TR_ACT) ? cmd_addr :
                {1'b0, rcw_tr, 3'h0, cmd_auto, cmd_addr[9:0]};
  assign a_prea = {1'b0, RCW_PRE, 3'h0, 1'b1, 10'h000};

  // next command on the pins, deselect by default
  assign kind_d = (ok_enter) ? K_ENTER :
                  (ok_set || ok_exit) ? K_SET :
                  exit_mrs ? K_EXIT :
                  ok_tr ? K_TR :
                  exit_prea ? K_PRE : K_DES;
  assign a_d = (ok_enter || ok_set || ok_exit || exit_mrs) ? a_mrs :
               ok_tr ? a_tr :
               exit_prea ? a_prea : 18'h00000;

  // programmed range and level
  assign range_d = ok_enter ? cmd_range : range_q;
  assign level_d = (ok_set || ok_exit) ? cmd_level : level_q;

  // open bank tracking
  always_comb begin
    open_d = open_q;
    if (exit_prea || (ok_tr && cmd_traffic == TR_PRE && cmd_auto)) begin
      open_d = 16'h0000;
    end else if (ok_tr && cmd_traffic == TR_ACT) begin
      open_d[cmd_bank] = 1'b1;
    end else if (ok_tr && (cmd_traffic == TR_PRE || cmd_auto)) begin
      open_d[cmd_bank] = 1'b0;
    end
  end

  // state sequence
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_OFF: begin
        if (ok_enter) begin
          state_d = S_CAL;
        end
      end
      S_CAL: begin
        if (ok_exit) begin
          state_d = S_EXIT_PRE;
        end
      end
      S_EXIT_PRE: begin
        if (wait_done) begin
          state_d = S_EXIT_MRS;
        end
      end
      S_EXIT_MRS: begin
        if (wait_done) begin
          state_d = S_EXIT_WAIT;
        end
      end
      S_EXIT_WAIT: begin
        if (wait_done) begin
          state_d = S_OFF;
        end
      end
    endcase
  end

  // ladder value of the operating setting and temperature drift
  assign bp_d = (ref_range_q == RANGE_LOWER ? LADDER_BASE_LOWER : LADDER_BASE_UPPER)
                + 14'(ref_level_q) * LADDER_STEP;
  assign tdiff = (temp_code >= cal_temp_q) ? temp_code - cal_temp_q : cal_temp_q - temp_code;
  assign recal_d = ref_valid_q && (tdiff > TEMP_DRIFT);

  // control state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_OFF;
      range_q <= RANGE_UPPER;
      level_q <= LEVEL_RESET;
      open_q <= 16'h0000;
      err_q <= 1'b0;
    end else begin
      state_q <= state_d;
      range_q <= range_d;
      level_q <= level_d;
      open_q <= open_d;
      err_q <= refuse;
    end
  end

  // operating reference, valid only once a calibration has finished
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ref_valid_q <= 1'b0;
      ref_range_q <= RANGE_UPPER;
      ref_level_q <= LEVEL_RESET;
      cal_temp_q <= TEMP_RESET;
      bp_q <= LADDER_BASE_UPPER;
      recal_q <= 1'b0;
    end else begin
      if (commit) begin
        ref_valid_q <= 1'b1;
        ref_range_q <= range_q;
        ref_level_q <= level_q;
        cal_temp_q <= temp_code;
      end
      bp_q <= bp_d;
      recal_q <= recal_d;
    end
  end

  // command pins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cs_n_q <= 1'b1;
      act_n_q <= 1'b1;
      bg_q <= 2'h0;
      ba_q <= 2'h0;
      a_q <= 18'h00000;
      kind_q <= K_DES;
    end else begin
      cs_n_q <= (kind_d == K_DES);
      act_n_q <= !(ok_tr && cmd_traffic == TR_ACT);
      bg_q <= ok_tr ? cmd_bank[3:2] : (kind_d == K_DES || kind_d == K_PRE) ? 2'h0 : REF_MR_BG;
      ba_q <= ok_tr ? cmd_bank[1:0] : (kind_d == K_DES || kind_d == K_PRE) ? 2'h0 : REF_MR_BA;
      a_q <= a_d;
      kind_q <= kind_d;
    end
  end

  assign cmd_err = err_q;
  assign ref_valid = ref_valid_q;
  assign ref_range = ref_range_q;
  assign ref_level = ref_level_q;
  assign ref_level_bp = bp_q;
  assign recal_needed = recal_q;
  assign ddr_cs_n = cs_n_q;
  assign ddr_act_n = act_n_q;
  assign ddr_bg = bg_q;
  assign ddr_ba = ba_q;
  assign ddr_a = a_q;

  // helper logic for the checks: gaps since commands on the pins
  dqc_kind_type last_q;
  logic [7:0] gap_q, since_lvl_q, lvl_need_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      last_q <= K_DES;
      gap_q <= 8'hff;
      since_lvl_q <= 8'hff;
      lvl_need_q <= 8'h00;
    end else begin
      if (kind_q != K_DES) begin
        last_q <= kind_q;
      end
      gap_q <= (kind_q != K_DES) ? 8'h01 : (gap_q == 8'hff ? gap_q : gap_q + 8'h01);
      since_lvl_q <= (kind_q == K_SET) ? 8'h01 :
                     (since_lvl_q == 8'hff ? since_lvl_q : since_lvl_q + 8'h01);
      if (ok_set || ok_exit) begin
        lvl_need_q <= settle_cyc;
      end
    end
  end

  default clocking dqc_cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_entry_spacing: assert property (
    kind_q != K_DES && last_q == K_ENTER |-> gap_q >= ENTRY_CYC)
    else $error("command too soon after calibration entry");
  a_exit_des_only: assert property (
    kind_q != K_DES && last_q == K_EXIT |-> gap_q >= EXIT_CYC)
    else $error("command too soon after calibration exit");
  a_settle_before_exit: assert property (
    kind_q == K_EXIT |-> since_lvl_q >= lvl_need_q)
    else $error("exit before level settled");
  a_range_kept: assert property (
    kind_q == K_SET || kind_q == K_EXIT |-> ddr_a[REF_RANGE_BIT] == range_q)
    else $error("range altered during calibration");
  a_no_reserved: assert property (
    kind_q == K_SET |-> ddr_a[REF_EN_BIT] && ddr_a[5:0] <= LEVEL_TOP)
    else $error("reserved level code written");
  a_entry_no_level: assert property (
    kind_q == K_ENTER |-> ddr_a[REF_EN_BIT] && ddr_a[5:0] == 6'h00)
    else $error("entry carries a level code");
  a_exit_idle_banks: assert property (
    kind_q == K_EXIT |-> open_q == 16'h0000 && !ddr_a[REF_EN_BIT])
    else $error("exit with banks open or enable set");
  a_exit_after_final: assert property (
    kind_q == K_EXIT |-> last_q == K_SET || last_q == K_PRE)
    else $error("exit not preceded by final level");
  a_pda_no_traffic: assert property (
    pda_active |=> kind_q != K_TR && kind_q != K_PRE)
    else $error("traffic issued under per-device addressing");
  a_ref_commit: assert property (
    $fell(cal_active) |-> ref_valid && ref_level == level_q && ref_range == range_q)
    else $error("operating reference not the last level");

  c_enter: cover property (kind_q == K_ENTER);
  c_long_step: cover property (ok_set && step_long);
  c_exit_done: cover property ($fell(cal_active));
  c_refused: cover property (refuse);
endmodule
`default_nettype wire

// [dqc_dev_model.sv]
// device-side model of the reference mode logic behind the command pins
// assumes the command pins are sampled on clk_sys rising edges; bad counts misuse
`default_nettype none
module dqc_dev_model
  import dqc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // command pins and addressing mode
  input wire logic ddr_cs_n,
  input wire logic ddr_act_n,
  input wire logic [1:0] ddr_bg,
  input wire logic [1:0] ddr_ba,
  input wire logic [17:0] ddr_a,
  input wire logic pda_active,
  // observed state
  output logic cal_q,
  output logic op_range_q,
  output logic [5:0] op_level_q,
  output logic [7:0] viol_q
);
  timeunit 1ns;
  timeprecision 100ps;
  logic rng_q;
  logic have_q;
  logic [5:0] lvl_q;
  logic [15:0] open_q;
  logic [7:0] since_q, req_q, ssince_q, sreq_q;
  // command decode
  wire cmd = !ddr_cs_n;
  wire act = cmd && !ddr_act_n;
  wire [2:0] rcw = ddr_a[16:14];
  wire mrs = cmd && ddr_act_n && rcw == RCW_MRS && ddr_bg == REF_MR_BG && ddr_ba == REF_MR_BA;
  wire pre = cmd && ddr_act_n && rcw == RCW_PRE;
  wire rdwr = cmd && ddr_act_n && (rcw == RCW_RD || rcw == RCW_WR);
  wire [3:0] bank = {ddr_bg, ddr_ba};
  wire en = ddr_a[REF_EN_BIT];
  wire [5:0] dlt = (ddr_a[5:0] > lvl_q) ? ddr_a[5:0] - lvl_q : lvl_q - ddr_a[5:0];
  // misuse: spacing, addressing mode, range change, reserved code, open banks
  wire bad = cmd && (since_q < req_q || ssince_q < sreq_q
    || (pda_active && !mrs)
    || (mrs && cal_q && en && (ddr_a[6] != rng_q || ddr_a[5:0] > LEVEL_TOP))
    || (mrs && cal_q && !en && open_q != 16'h0000)
    || (rdwr && !open_q[bank]));
  // mode state, operating setting and command spacing
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cal_q <= 1'b0;
      rng_q <= 1'b0;
      have_q <= 1'b0;
      lvl_q <= 6'h00;
      op_range_q <= 1'b0;
      op_level_q <= 6'h00;
      open_q <= 16'h0000;
      viol_q <= 8'h00;
      since_q <= 8'hff;
      ssince_q <= 8'hff;
      req_q <= 8'h00;
      sreq_q <= 8'h00;
    end else begin
      since_q <= (since_q == 8'hff) ? since_q : since_q + 8'h01;
      ssince_q <= (ssince_q == 8'hff) ? ssince_q : ssince_q + 8'h01;
      if (bad) begin
        viol_q <= viol_q + 8'h01;
      end
      if (cmd) begin
        since_q <= 8'h01;
        req_q <= 8'h00;
      end
      if (act) begin
        open_q[bank] <= 1'b1;
      end
      if (pre) begin
        open_q <= ddr_a[ADDR_AUTO_BIT] ? 16'h0000 : open_q & ~(16'h0001 << bank);
      end
      if (rdwr && ddr_a[ADDR_AUTO_BIT]) begin
        open_q[bank] <= 1'b0;
      end
      if (mrs && en && !cal_q) begin
        cal_q <= 1'b1;
        rng_q <= ddr_a[REF_RANGE_BIT];
        have_q <= 1'b0;
        req_q <= ENTRY_CYC;
      end
      if (mrs && en && cal_q) begin
        lvl_q <= ddr_a[5:0];
        have_q <= 1'b1;
        ssince_q <= 8'h01;
        sreq_q <= (have_q && dlt > LONG_STEP_THRESH) ? SETTLE_LONG_CYC : SETTLE_SHORT_CYC;
      end
      if (mrs && !en && cal_q) begin
        cal_q <= 1'b0;
        op_range_q <= rng_q;
        op_level_q <= lvl_q;
        req_q <= EXIT_CYC;
      end
    end
  end
endmodule
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the reference calibration controller
// assumes dqc_pkg and the device model are compiled first
`default_nettype none
module tb_top;
  import dqc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, rst_n, cmd_valid, cmd_range, cmd_auto, pda_active;
  logic cmd_ready, cmd_err, cal_active, ref_valid, ref_range, recal_needed;
  logic ddr_cs_n, ddr_act_n, m_cal, m_range;
  logic [1:0] cmd_op, cmd_traffic, ddr_bg, ddr_ba;
  logic [5:0] cmd_level, ref_level, m_level, fin;
  logic [3:0] cmd_bank;
  logic [17:0] cmd_addr, ddr_a;
  logic [7:0] temp_code, m_viol;
  logic [13:0] ref_level_bp;
  int failures, comparisons, n;
  // design and device model
  dqc_calibration_ctrl dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_range(cmd_range), .cmd_level(cmd_level), .cmd_traffic(cmd_traffic),
    .cmd_auto(cmd_auto), .cmd_bank(cmd_bank), .cmd_addr(cmd_addr), .cmd_ready(cmd_ready),
    .cmd_err(cmd_err), .pda_active(pda_active), .temp_code(temp_code),
    .cal_active(cal_active), .ref_valid(ref_valid), .ref_range(ref_range),
    .ref_level(ref_level), .ref_level_bp(ref_level_bp), .recal_needed(recal_needed),
    .ddr_cs_n(ddr_cs_n), .ddr_act_n(ddr_act_n), .ddr_bg(ddr_bg), .ddr_ba(ddr_ba), .ddr_a(ddr_a));
  dqc_dev_model model_u (.clk_sys(clk_sys), .rst_n(rst_n), .ddr_cs_n(ddr_cs_n),
    .ddr_act_n(ddr_act_n), .ddr_bg(ddr_bg), .ddr_ba(ddr_ba), .ddr_a(ddr_a),
    .pda_active(pda_active), .cal_q(m_cal), .op_range_q(m_range), .op_level_q(m_level),
    .viol_q(m_viol));
  // clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic close_out;
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // one order: wait for ready, hold valid across the taking edge, look at the answer cycle
  task automatic order(input logic [1:0] op, input logic rng, input logic [5:0] lvl,
      input logic [1:0] tr, input logic exp_err);
    int k;
    k = 0;
    @(posedge clk_sys);
    #1;
    while (cmd_ready !== 1'b1 && k < 50) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    if (k == 50) begin
      failures++;
    end
    cmd_op = op;
    cmd_range = rng;
    cmd_level = lvl;
    cmd_traffic = tr;
    cmd_valid = 1'b1;
    @(posedge clk_sys);
    #1;
    cmd_valid = 1'b0;
    check(cmd_err, exp_err);
  endtask
  // let a few cycles pass
  task automatic idle(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask
  // watchdog
  initial begin
    repeat (3000) @(posedge clk_sys);
    failures++;
    close_out;
  end
  // main sequence
  initial begin
    {cmd_valid, cmd_range, cmd_auto, pda_active, cmd_op, cmd_traffic, cmd_level} = '0;
    cmd_bank = 4'h6;
    cmd_addr = 18'h00123;
    temp_code = 8'h20;
    rst_n = 1'b0;
    repeat (16) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    check(ref_valid, 1'b0);
    check(ref_level_bp, 14'h1770);
    order(OP_SET, 1'b0, 6'h05, TR_ACT, 1'b1);
    order(OP_TRAFFIC, 1'b0, 6'h00, TR_WR, 1'b1);
    for (int r = 0; r < 2; r++) begin
      fin = r[0] ? 6'h00 : 6'h32;
      order(OP_ENTER, r[0], 6'h15, TR_ACT, 1'b0);
      check(ddr_a, 18'h00080 | (18'(r) << 6));
      check(cal_active, 1'b1);
      check({ddr_cs_n, ddr_act_n, ddr_bg, ddr_ba}, {1'b0, 1'b1, REF_MR_BG, REF_MR_BA});
      order(OP_ENTER, r[0], 6'h00, TR_ACT, 1'b1);
      order(OP_TRAFFIC, r[0], 6'h00, TR_ACT, 1'b0);
      order(OP_TRAFFIC, r[0], 6'h00, TR_WR, 1'b0);
      order(OP_SET, r[0], 6'h33, TR_ACT, 1'b1);
      order(OP_SET, r[0], 6'h32, TR_ACT, 1'b0);
      check(ddr_a[7:0], {1'b1, r[0], 6'h32});
      check(cmd_ready, 1'b0);
      order(OP_SET, r[0], 6'h01, TR_ACT, 1'b0);
      pda_active = 1'b1;
      order(OP_TRAFFIC, r[0], 6'h00, TR_RD, 1'b1);
      order(OP_SET, r[0], 6'h03, TR_ACT, 1'b0);
      order(OP_EXIT, r[0], fin, TR_ACT, 1'b1);
      pda_active = 1'b0;
      cmd_auto = r[0];
      order(OP_TRAFFIC, r[0], 6'h00, TR_RD, 1'b0);
      check(ddr_a, {1'b0, RCW_RD, 3'h0, r[0], 10'h123});
      if (r[0]) begin
        order(OP_TRAFFIC, r[0], 6'h00, TR_PRE, 1'b0);
      end
      cmd_auto = 1'b0;
      order(OP_EXIT, r[0], fin, TR_ACT, 1'b0);
      check(ddr_a[7:0], {1'b1, r[0], fin});
      n = 0;
      while (cal_active !== 1'b0 && n < 40) begin
        idle(1);
        n++;
      end
      check(cal_active, 1'b0);
      idle(1);
      check(ref_valid, 1'b1);
      check({ref_range, ref_level}, {r[0], fin});
      check({m_cal, m_range, m_level}, {1'b0, r[0], fin});
      check(ref_level_bp, (r[0] ? 14'h1194 : 14'h1770) + 14'h0041 * 14'(fin));
      check(recal_needed, 1'b0);
      temp_code = 8'h2b;
      idle(3);
      check(recal_needed, 1'b1);
      temp_code = 8'h2a;
      idle(3);
      check(recal_needed, 1'b0);
      temp_code = 8'h20;
    end
    check(m_viol, 8'h00);
    close_out;
  end
endmodule
`default_nettype wire
